// [hdl/fspc_top.sv]
`timescale 1ns/10ps
`include "fspc_consts.svh"
module fspc_top import fspc_pkg::*; #(
    parameter int PAGE_WORDS = 32,
    parameter int TICK_CYCLES = `FSPC_TICK_NS * `FSPC_CLK_KHZ / 1000000,
    parameter int OP_TICKS = (`FSPC_OP_MIN_NS + `FSPC_TICK_NS - 1) / `FSPC_TICK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fspc_cpu_req_type cpu_req,
    input wire logic eeprom_write_busy,
    input wire logic global_irq_flag,
    input wire logic [7:0] fuse_low_programmed,
    input wire logic [7:0] fuse_high_programmed,
    input wire logic [7:0] fuse_ext_programmed,
    input wire logic [1:0] lock_programmed,
    input wire logic [$clog2(PAGE_WORDS)-1:0] pbuf_rd_addr,
    output logic [15:0] pbuf_rd_data,
    output logic cpu_halt,
    output logic lpm_sub_valid,
    output logic [7:0] lpm_sub_data,
    output logic program_ready_irq,
    output logic flash_erase_go,
    output logic flash_write_go,
    output logic [15-$clog2(PAGE_WORDS)-1:0] flash_page_addr
);
    localparam int WAW = $clog2(PAGE_WORDS);
    localparam int PAGE_LSB = WAW + 1;
    localparam int PAW = 16 - PAGE_LSB;
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);

    // ============================================================
    // elaboration checks
    generate
        if (PAGE_WORDS < 2 || PAGE_WORDS > 4096 || (1 << WAW) != PAGE_WORDS) begin : g_bad_page
            $error("page size must be a power of two from 2 to 4096 words");
        end
        if (TICK_CYCLES < 1) begin : g_bad_tick
            $error("tick divider needs at least one cycle");
        end
    endgenerate

    // ============================================================
    // helper functions

    // true for the five accepted low encodings
    function automatic logic fspc_legal(input logic [4:0] enc);
        fspc_legal = (enc == `FSPC_ENC_SECTRE) || (enc == `FSPC_ENC_LOCKRD)
            || (enc == `FSPC_ENC_WRITE) || (enc == `FSPC_ENC_ERASE)
            || (enc == `FSPC_ENC_FILL);
    endfunction

    // fuse or lock byte selected by the pointer, inverted flags
    function automatic logic [7:0] fspc_fuse_sel(
        input logic [15:0] z,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] ext,
        input logic [1:0] lk
    );
        fspc_fuse_sel = 8'hff;
        if (z == `FSPC_ADDR_FUSE_LOW) begin
            fspc_fuse_sel = ~lo;
        end else if (z == `FSPC_ADDR_LOCK) begin
            fspc_fuse_sel = {6'h3f, ~lk};
        end else if (z == `FSPC_ADDR_FUSE_EXT) begin
            fspc_fuse_sel = ~ext;
        end else if (z == `FSPC_ADDR_FUSE_HIGH) begin
            fspc_fuse_sel = ~hi;
        end
    endfunction

    // ============================================================
    // declarations
    logic irq_en;
    logic sect_re;
    logic lock_sel;
    logic page_write_cmd;
    logic page_erase_cmd;
    logic spe;
    logic [2:0] window;
    fspc_op_type op_kind;
    logic op_busy;
    logic op_done;
    logic op_start;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic apb_access;
    logic apb_hit;
    logic ctrl_wr;
    logic [4:0] wr_enc;
    logic cmd_ok;
    logic spm_take;
    logic lpm_take;
    logic fill_take;
    logic window_lapse;
    logic pbuf_clear;
    logic [7:0] status;

    // ============================================================
    // apb decode
    assign apb_access = psel && penable && pready;
    assign apb_hit = (paddr == `FSPC_CTRL_OFF);
    assign ctrl_wr = apb_access && pwrite && apb_hit;
    assign wr_enc = pwdata[4:0];

    // command accepted only when legal, idle and no eeprom write
    assign cmd_ok = ctrl_wr && fspc_legal(wr_enc)
        && !eeprom_write_busy
        && !op_busy;

    // register image; section busy and reserved read zero
    assign status = {irq_en, 1'b0, 1'b0, sect_re, lock_sel,
        page_write_cmd || (op_busy && op_kind == FSPC_OP_WRITE),
        page_erase_cmd || (op_busy && op_kind == FSPC_OP_ERASE),
        spe || op_busy};

    // ============================================================
    // instruction window
    assign spm_take = cpu_req.spm && spe && (window != 3'h0)
        && !eeprom_write_busy && !op_busy;
    assign lpm_take = cpu_req.lpm && spe && lock_sel
        && (window > (`FSPC_SPM_WINDOW - `FSPC_LPM_WINDOW))
        && !eeprom_write_busy;
    assign fill_take = spm_take && !page_write_cmd && !page_erase_cmd && !lock_sel && !sect_re;
    assign window_lapse = (window == 3'h1) && !spm_take && !lpm_take;
    assign op_start = spm_take && (page_write_cmd || page_erase_cmd);

    // one down counter for all command windows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window <= 3'h0;
        end else if (cmd_ok) begin
            window <= `FSPC_SPM_WINDOW;
        end else if (spm_take || lpm_take) begin
            window <= 3'h0;
        end else if (window != 3'h0) begin
            window <= window - 3'h1;
        end
    end

    // ============================================================
    // control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sect_re, lock_sel, page_write_cmd, page_erase_cmd, spe} <= 5'(`FSPC_CTRL_RESET);
        end else if (cmd_ok) begin
            {sect_re, lock_sel, page_write_cmd, page_erase_cmd, spe} <= wr_enc;
        end else if (spm_take || lpm_take || window_lapse) begin
            // auto clear on use or lapse
            sect_re <= 1'b0;
            lock_sel <= 1'b0;
            page_write_cmd <= 1'b0;
            page_erase_cmd <= 1'b0;
            spe <= 1'b0;
        end
    end

    // interrupt enable stored on any register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= 1'(`FSPC_CTRL_RESET >> `FSPC_BIT_IRQEN);
        end else if (ctrl_wr) begin
            irq_en <= pwdata[`FSPC_BIT_IRQEN];
        end
    end

    // ============================================================
    // apb answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !apb_hit;
            if (psel && !penable && !pwrite && apb_hit) begin
                prdata <= {24'h00_0000, status};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // oscillator tick divider, survives system reset
    always_ff @(posedge pclk or negedge flash_por_n) begin
        if (!flash_por_n) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (div_cnt == DIV_W'(TICK_CYCLES - 1)) begin
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
            tick <= 1'b0;
        end
    end

    // operation length in oscillator ticks
    fspc_op_timer #(
        .TICKS(OP_TICKS)
    ) u_timer (
        .pclk(pclk),
        .rst_n(flash_por_n),
        .tick(tick),
        .start(op_start),
        .busy(op_busy),
        .done(op_done)
    );

    // ============================================================
    // flash operation kind, held across system reset
    always_ff @(posedge pclk or negedge flash_por_n) begin
        if (!flash_por_n) begin
            op_kind <= FSPC_OP_NONE;
        end else begin
            case (op_kind)
                FSPC_OP_NONE: begin
                    if (op_start && page_write_cmd) begin
                        op_kind <= FSPC_OP_WRITE;
                    end else if (op_start) begin
                        op_kind <= FSPC_OP_ERASE;
                    end
                end
                FSPC_OP_ERASE: begin
                    if (op_done) begin
                        op_kind <= FSPC_OP_NONE;
                    end
                end
                FSPC_OP_WRITE: begin
                    if (op_done) begin
                        op_kind <= FSPC_OP_NONE;
                    end
                end
                default: begin
                    op_kind <= FSPC_OP_NONE;
                end
            endcase
        end
    end

    // start pulses and page address toward the flash array
    always_ff @(posedge pclk or negedge flash_por_n) begin
        if (!flash_por_n) begin
            flash_erase_go <= 1'b0;
            flash_write_go <= 1'b0;
            flash_page_addr <= '0;
        end else begin
            flash_write_go <= op_start && page_write_cmd;
            flash_erase_go <= op_start && !page_write_cmd;
            if (op_start) begin
                flash_page_addr <= cpu_req.z_ptr[15:PAGE_LSB];
            end
        end
    end

    // cpu held from store until the operation ends
    always_ff @(posedge pclk or negedge flash_por_n) begin
        if (!flash_por_n) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= op_start || (op_busy && !op_done);
        end
    end

    // ============================================================
    // temporary page buffer
    assign pbuf_clear = (op_done && op_kind == FSPC_OP_WRITE)
        || (cmd_ok && wr_enc == `FSPC_ENC_SECTRE);

    fspc_page_buffer #(
        .WORDS(PAGE_WORDS),
        .AW(WAW)
    ) u_pbuf (
        .pclk(pclk),
        .presetn(presetn),
        .clear(pbuf_clear),
        .wr_en(fill_take),
        .wr_addr(cpu_req.z_ptr[WAW:1]),
        .wr_data(cpu_req.word),
        .rd_addr(pbuf_rd_addr),
        .rd_data(pbuf_rd_data)
    );

    // ============================================================
    // fuse and lock readback toward the load instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lpm_sub_valid <= 1'b0;
            lpm_sub_data <= 8'hff;
        end else begin
            lpm_sub_valid <= lpm_take;
            if (lpm_take) begin
                lpm_sub_data <= fspc_fuse_sel(cpu_req.z_ptr, fuse_low_programmed,
                    fuse_high_programmed, fuse_ext_programmed,
                    lock_programmed);
            end
        end
    end

    // ============================================================
    // ready interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_ready_irq <= 1'b0;
        end else begin
            program_ready_irq <= irq_en && global_irq_flag && !(spe || op_busy);
        end
    end
endmodule

// [pkg/fspc_consts.svh]
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// ============================================================
// register map
`define FSPC_CTRL_OFF 12'h000
`define FSPC_CTRL_RESET 8'h00

// ============================================================
// control register bit positions
`define FSPC_BIT_SPE 0
`define FSPC_BIT_ERASE 1
`define FSPC_BIT_WRITE 2
`define FSPC_BIT_LOCKSEL 3
`define FSPC_BIT_SECTRE 4
`define FSPC_BIT_BUSYSEC 6
`define FSPC_BIT_IRQEN 7

// ============================================================
// accepted encodings of the low five control bits
`define FSPC_ENC_SECTRE 5'h11
`define FSPC_ENC_LOCKRD 5'h09
`define FSPC_ENC_WRITE 5'h05
`define FSPC_ENC_ERASE 5'h03
`define FSPC_ENC_FILL 5'h01

// ============================================================
// instruction windows in clock cycles
`define FSPC_SPM_WINDOW 3'h4
`define FSPC_LPM_WINDOW 3'h3

// ============================================================
// fuse and lock read addresses on the address pointer
`define FSPC_ADDR_FUSE_LOW 16'h0000
`define FSPC_ADDR_LOCK 16'h0001
`define FSPC_ADDR_FUSE_EXT 16'h0002
`define FSPC_ADDR_FUSE_HIGH 16'h0003

// ============================================================
// flash operation timing
`define FSPC_CLK_KHZ 40000
`define FSPC_OP_MIN_NS 3700000
`define FSPC_OP_MAX_NS 4500000
`define FSPC_TICK_NS 1000

`endif

// [pkg/fspc_pkg.sv]
package fspc_pkg;

    // one instruction report from the cpu core
    typedef struct packed {
        logic spm;
        logic lpm;
        logic [15:0] z_ptr;
        logic [15:0] word;
    } fspc_cpu_req_type;

    // flash operation in progress
    typedef enum logic [1:0] {
        FSPC_OP_NONE = 2'b00,
        FSPC_OP_ERASE = 2'b01,
        FSPC_OP_WRITE = 2'b10
    } fspc_op_type;

endpackage

// [hdl/fspc_page_buffer.sv]
`timescale 1ns/10ps
module fspc_page_buffer #(
    parameter int WORDS = 32,
    parameter int AW = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [WORDS];
    logic [WORDS-1:0] filled;

    generate
        if (WORDS < 2 || WORDS != (1 << AW)) begin : g_bad_words
            $error("page buffer needs a power of two words matching its address width");
        end
    endgenerate

    // fill flags, emptied by reset or clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filled <= '0;
        end else if (clear) begin
            filled <= '0;
        end else if (wr_en && !filled[wr_addr]) begin
            filled[wr_addr] <= 1'b1;
        end
    end

    // a word is written once until the buffer is cleared
    always_ff @(posedge pclk) begin
        if (wr_en && !filled[wr_addr] && !clear) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // unfilled words read as erased flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 16'hffff;
        end else begin
            rd_data <= filled[rd_addr] ? mem[rd_addr] : 16'hffff;
        end
    end
endmodule

// [hdl/fspc_op_timer.sv]
`timescale 1ns/10ps
module fspc_op_timer #(
    parameter int TICKS = 3700
) (
    input wire logic pclk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(TICKS + 1);
    logic [CW-1:0] left;

    generate
        if (TICKS < 1) begin : g_bad
            $error("op timer needs at least one tick");
        end
    endgenerate

    // counts oscillator ticks while an operation runs
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            left <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                left <= CW'(TICKS);
                busy <= 1'b1;
            end else if (busy && tick) begin
                if (left == CW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                left <= left - CW'(1);
            end
        end
    end
endmodule

// [bench/fspc_cpu_model.sv]
`timescale 1ns/10ps
// ====================
// cpu core reporting store and load instructions
module fspc_cpu_model import fspc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_halt,
    input wire logic do_spm,
    input wire logic do_lpm,
    input wire logic [15:0] z_in,
    input wire logic [15:0] w_in,
    output fspc_cpu_req_type cpu_req
);
    // halted core runs nothing; stale operands keep toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_req <= '0;
        end else if ((do_spm || do_lpm) && !cpu_halt) begin
            cpu_req <= {do_spm, do_lpm, z_in, w_in};
        end else begin
            cpu_req <= {2'b00, ~cpu_req.z_ptr, ~cpu_req.word};
        end
    end
endmodule

// [bench/fspc_top_properties.sv]
`timescale 1ns/10ps
// ====================
// port checker of the controller
module fspc_top_properties import fspc_pkg::*; #(
    parameter int TICK_CYCLES = 40,
    parameter int OP_TICKS = 3700
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_por_n,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire fspc_cpu_req_type cpu_req,
    input wire logic eeprom_write_busy,
    input wire logic [7:0] fuse_low_programmed,
    input wire logic [1:0] lock_programmed,
    input wire logic cpu_halt,
    input wire logic lpm_sub_valid,
    input wire logic [7:0] lpm_sub_data,
    input wire logic flash_erase_go,
    input wire logic flash_write_go
);
    localparam int LO = (OP_TICKS - 1) * TICK_CYCLES;
    localparam int HI = (OP_TICKS + 1) * TICK_CYCLES + 2;
    logic [31:0] halt_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====================
    // length of the running halt
    always_ff @(posedge pclk or negedge flash_por_n) begin
        if (!flash_por_n) begin
            halt_cnt <= '0;
        end else begin
            halt_cnt <= cpu_halt ? halt_cnt + 32'h1 : 32'h0;
        end
    end
    // ====================
    // operation steps and checks
    sequence s_launch;
        (flash_erase_go || flash_write_go) && cpu_halt;
    endsequence
    sequence s_lock_ask;
        cpu_req.lpm && cpu_req.z_ptr == 16'h0001 ##1 lpm_sub_valid;
    endsequence
    sequence s_low_ask;
        cpu_req.lpm && cpu_req.z_ptr == 16'h0000 ##1 lpm_sub_valid;
    endsequence
    property p_status_zero;
        pready && !pwrite |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status bits");
    property p_halt_with_go;
        $rose(cpu_halt) |-> s_launch;
    endproperty
    a_halt_with_go: assert property (p_halt_with_go) else $error("halt");
    property p_halt_len;
        $fell(cpu_halt) |-> halt_cnt >= LO && halt_cnt <= HI;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("op length");
    property p_go_after_spm;
        (flash_erase_go || flash_write_go) |-> $past(cpu_req.spm);
    endproperty
    a_go_after_spm: assert property (p_go_after_spm) else $error("go");
    property p_ee_blocks;
        flash_erase_go || flash_write_go || lpm_sub_valid |-> !$past(eeprom_write_busy);
    endproperty
    a_ee_blocks: assert property (p_ee_blocks) else $error("eeprom");
    property p_busy_bit;
        pready && !pwrite && cpu_halt && $past(cpu_halt) |-> prdata[0];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit");
    property p_lpm_cause;
        lpm_sub_valid |-> $past(cpu_req.lpm);
    endproperty
    a_lpm_cause: assert property (p_lpm_cause) else $error("load");
    property p_lock;
        s_lock_ask |-> lpm_sub_data == {6'h3f, ~lock_programmed};
    endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_low;
        s_low_ask |-> lpm_sub_data == ~fuse_low_programmed;
    endproperty
    a_low: assert property (p_low) else $error("fuse");
endmodule
bind fspc_top fspc_top_properties #(.TICK_CYCLES(TICK_CYCLES), .OP_TICKS(OP_TICKS)) u_props (
    .pclk(pclk), .presetn(presetn), .flash_por_n(flash_por_n), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .cpu_req(cpu_req), .eeprom_write_busy(eeprom_write_busy),
    .fuse_low_programmed(fuse_low_programmed), .lock_programmed(lock_programmed),
    .cpu_halt(cpu_halt), .lpm_sub_valid(lpm_sub_valid), .lpm_sub_data(lpm_sub_data),
    .flash_erase_go(flash_erase_go), .flash_write_go(flash_write_go));

// [bench/fspc_top_bench.sv]
`timescale 1ns/10ps
`include "fspc_consts.svh"
module fspc_top_bench;
    import fspc_pkg::*;
    logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic ee = 0, gif = 0, ds = 0, dl = 0, pready, pslverr, er, halt, lv, irq, eg, wg;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] ld, flo = 8'h5a, fhi = 8'h0f, fex = 8'hc3;
    logic [1:0] lk = 2'b01;
    logic [4:0] pa = '0;
    logic [15:0] pd, z = '0, w = '0;
    logic [9:0] pg;
    logic [7:0] fexp [4] = '{8'ha5, 8'hfe, 8'h3c, 8'hf0};
    logic [7:0] bad [4] = '{8'h07, 8'h02, 8'h0f, 8'h13};
    fspc_cpu_req_type req;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n, nv = 0;
    // ====================
    // clock, design and core
    always #12.5 pclk = ~pclk;
    fspc_top #(.PAGE_WORDS(32), .TICK_CYCLES(2), .OP_TICKS(5)) DUT (
        .pclk(pclk), .presetn(presetn), .flash_por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(req),
        .eeprom_write_busy(ee), .global_irq_flag(gif), .fuse_low_programmed(flo),
        .fuse_high_programmed(fhi), .fuse_ext_programmed(fex),
        .lock_programmed(lk), .pbuf_rd_addr(pa), .pbuf_rd_data(pd),
        .cpu_halt(halt), .lpm_sub_valid(lv), .lpm_sub_data(ld),
        .program_ready_irq(irq), .flash_erase_go(eg), .flash_write_go(wg),
        .flash_page_addr(pg));
    fspc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_halt(halt), .do_spm(ds),
        .do_lpm(dl), .z_in(z), .w_in(w), .cpu_req(req));
    // ====================
    // tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task cmd(input logic [7:0] c);
        apb(1, `FSPC_CTRL_OFF, {24'h0, c});
    endtask
    task rdst(input logic [7:0] e);
        apb(0, `FSPC_CTRL_OFF, '0);
        chk("status", {24'h0, e}, rd);
    endtask
    task ins(input logic s, input int dly, input logic [15:0] zz, input logic [15:0] ww);
        @(posedge pclk);
        repeat (dly) @(posedge pclk);
        ds <= s;
        dl <= !s;
        z <= zz;
        w <= ww;
        @(posedge pclk);
        ds <= 0;
        dl <= 0;
    endtask
    task pbuf(input logic [4:0] a, input logic [15:0] e);
        pa <= a;
        repeat (3) @(posedge pclk);
        chk("pbuf", {16'h0, e}, {16'h0, pd});
    endtask
    task wait_end;
        n = 0;
        while (halt === 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("op_end", 0, {31'h0, halt});
    endtask
    task op(input logic [7:0] c, input logic [15:0] zz);
        cmd(c);
        ins(1, 0, zz, 16'h0);
        repeat (2) @(posedge pclk);
        chk("halt", 1, {31'h0, halt});
        chk("go", {30'h0, c[2:1]}, {30'h0, wg, eg});
        rdst(c);
        chk("page", {22'h0, zz[15:6]}, {22'h0, pg});
        wait_end();
        rdst(8'h00);
    endtask
    task end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ====================
    // load answer counter and hang guard
    always @(posedge pclk) begin
        if (lv === 1'b1) nv++;
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ====================
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        por_n <= 1;
        rdst(8'h00);
        apb(0, 12'h004, '0);
        chk("slverr", 1, {31'h0, er});
        gif <= 1;
        cmd(8'h80);
        repeat (2) @(posedge pclk);
        chk("irq", 1, {31'h0, irq});
        cmd(8'h81);
        repeat (2) @(posedge pclk);
        chk("irq", 0, {31'h0, irq});
        repeat (6) @(posedge pclk);
        chk("irq", 1, {31'h0, irq});
        rdst(8'h80);
        foreach (bad[i]) begin
            cmd(bad[i]);
            rdst(8'h00);
        end
        cmd(8'h01);
        ins(1, 0, 16'h0000, 16'h1234);
        rdst(8'h00);
        cmd(8'h01);
        ins(1, 1, 16'h003f, 16'hbeef);
        pbuf(5'd0, 16'h1234);
        pbuf(5'd31, 16'hbeef);
        cmd(8'h01);
        ins(1, 2, 16'h0002, 16'h5555);
        pbuf(5'd1, 16'hffff);
        cmd(8'h11);
        pbuf(5'd0, 16'hffff);
        cmd(8'h01);
        ins(1, 0, 16'h0004, 16'h7777);
        op(8'h03, 16'h1fc0);
        pbuf(5'd2, 16'h7777);
        op(8'h05, 16'h1fc0);
        pbuf(5'd2, 16'hffff);
        cmd(8'h03);
        ins(1, 0, 16'h0040, 16'h0);
        repeat (2) @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk("halt_rst", 1, {31'h0, halt});
        wait_end();
        for (int i = 0; i < 4; i++) begin
            cmd(8'h09);
            ins(0, 0, 16'(i), 16'h0);
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (lv !== 1'b1 && n < 6);
            chk("fuse", {24'h0, fexp[i]}, {24'h0, ld});
        end
        rdst(8'h00);
        cmd(8'h09);
        ins(0, 1, 16'h0001, 16'h0);
        rdst(8'h00);
        ins(0, 0, 16'h0000, 16'h0);
        ee <= 1;
        cmd(8'h01);
        rdst(8'h00);
        cmd(8'h09);
        ins(0, 0, 16'h0001, 16'h0);
        cmd(8'h03);
        ins(1, 0, 16'h0000, 16'h0);
        repeat (3) @(posedge pclk);
        chk("ee_halt", 0, {31'h0, halt});
        ee <= 0;
        chk("loads", 4, nv);
        end_of_test();
    end
endmodule
